// *** bench/mscr_host.sv ***
// serial bus host model driving clock and open-drain data toward the bank
`default_nettype none
module mscr_host (
    // clock
    input  wire logic i_clock,
    // bus wire levels
    input  wire logic i_sda_level,
    output logic      o_scl,
    output logic      o_sda_low
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge i_clock);
    endtask

    // data moves only while clock is low, sampled mid high phase
    task automatic bit_xfer(input logic b, output logic s);
        o_sda_low = ~b;
        tick(2);
        o_scl = 1'b1;
        tick(2);
        s = i_sda_level;
        tick(2);
        o_scl = 1'b0;
        tick(2);
    endtask

    task automatic start_cond();
        o_sda_low = 1'b0;
        tick(2);
        o_scl = 1'b1;
        tick(4);
        o_sda_low = 1'b1;
        tick(4);
        o_scl = 1'b0;
        tick(2);
    endtask

    task automatic stop_cond();
        o_sda_low = 1'b1;
        tick(2);
        o_scl = 1'b1;
        tick(4);
        o_sda_low = 1'b0;
        tick(4);
    endtask

    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(v[i], s);
        end
        bit_xfer(1'b1, s);
        ack = ~s;
    endtask

    task automatic recv_byte(input logic last, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, v[i]);
        end
        bit_xfer(last, s);
    endtask

    // pointer then one data byte, all acks folded into ok
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] data,
                             output logic ok);
        logic a0, a1, a2;
        start_cond();
        send_byte({dev, 1'b0}, a0);
        send_byte(ptr, a1);
        send_byte(data, a2);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask

    // pointer, repeated start, one byte read with closing nack
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] data,
                            output logic ok);
        logic a0, a1, a2;
        start_cond();
        send_byte({dev, 1'b0}, a0);
        send_byte(ptr, a1);
        start_cond();
        send_byte({dev, 1'b1}, a2);
        recv_byte(1'b1, data);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask
endmodule // mscr_host
`default_nettype wire

// *** bench/mscr_top_test.sv ***
// self-checking bench for the mode configuration bank
`default_nettype none
module mscr_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [6:0]  DEV           = 7'h2a;
    localparam logic [15:0] SET1_OPS [7]  = '{16'h2880, 16'h28f5, 16'h2940, 16'h29b8, 16'h29ff, 16'h2959,
                                              16'h29a0};
    localparam logic [7:0]  SET2_DATA [6] = '{8'h28, 8'h29, 8'h3e, 8'h3f, 8'h80, 8'h00};

    logic                 clock, rst, scl, sda_low, sda_level, sda_out, sda_oe, ok;
    logic                 reg_lo, reg_hi, pin_lo, pin_hi, src_other;
    logic [1:0]           active;
    logic [7:0]           rd;
    logic [7:0]           shadow [4];
    mscr_pkg::mscr_ctrl_t other, ctrl;
    int                   mismatches, compares;

    assign sda_level = ~(sda_low | sda_oe);

    mscr_top #(.DEVICE_ADDR(DEV)) dut (
        .i_clock(clock), .i_rst(rst), .i_scl(scl), .i_sda(sda_level),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .i_register_mode_bit_low(reg_lo), .i_register_mode_bit_high(reg_hi),
        .i_mode_select_pin_low(pin_lo), .i_mode_select_pin_high(pin_hi),
        .i_mode_source_pin_select_other(src_other), .i_other_ctrl(other),
        .o_active_mode(active), .o_ctrl(ctrl)
    );

    mscr_host host (.i_clock(clock), .i_sda_level(sda_level), .o_scl(scl), .o_sda_low(sda_low));

    always #4 clock = ~clock;

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] seen);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic mscr_pkg::mscr_ctrl_t expect_ctrl(input logic [1:0] mode);
        mscr_pkg::mscr_ctrl_t e;
        logic [7:0]           c;
        e = other;
        if (mode == 2'h1) begin
            {e.core_buck_en, e.system_buck_en, e.aon_en, e.sysreg_en} = shadow[0][3:0];
            c = {4'h0, shadow[0][7:4]};
            c = (c > 8'h08) ? 8'h08 : c;
            e.aon_mv = 12'h06a4 + 12'(c) * 12'h0019;
            c = {3'h0, shadow[1][4:0]};
            c = (c > 8'h18) ? 8'h18 : c;
            e.sysreg_mv = 12'h05dc + 12'(c) * 12'h0019 + (shadow[1][5] ? 12'h04b0 : 12'h0000);
            e.watchdog_s = (shadow[1][7:6] == 2'h0) ? 7'h00 : 7'(7'h08 << shadow[1][7:6]);
        end else if (mode == 2'h2) begin
            e.ship = shadow[2][7];
            c = {2'h0, shadow[2][5:0]};
            c = (c > 8'h28) ? 8'h28 : c;
            e.core_buck_mv = (shadow[2][5:0] == 6'h3f) ? 12'h0708 : 12'h01f4 + 12'(c) * 12'h0019;
        end
        return e;
    endfunction

    task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
        host.write_reg(DEV, ptr, data, ok);
        check("write ack", 64'h1, 64'(ok));
        if (ptr inside {8'h28, 8'h29, 8'h2a}) begin
            shadow[ptr[1:0]] = data;
        end
    endtask

    task automatic rd_check(input logic [7:0] ptr, input logic [7:0] exp);
        host.read_reg(DEV, ptr, rd, ok);
        check("read ack", 64'h1, 64'(ok));
        check("read data", 64'(exp), 64'(rd));
    endtask

    task automatic settle_check(input logic [1:0] mode);
        repeat (4) @(negedge clock);
        check("active mode", 64'(mode), 64'(active));
        check("controls", 64'(expect_ctrl(mode)), 64'(ctrl));
        check("sda drive value", 64'h0, 64'(sda_out));
    endtask

    task automatic reset_pulse();
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        shadow = '{8'h4f, 8'h0c, 8'h1c, 8'h00};
        @(negedge clock);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clock);
        mismatches++;
        $display("unexpected run length expected %h seen %h", 1'b0, 1'b1);
        tally_and_finish();
    end

    initial begin
        clock = 1'b0;
        {reg_lo, reg_hi, pin_lo, pin_hi, src_other} = 5'h00;
        other = mscr_pkg::mscr_ctrl_t'(48'h1234_5678_9abc);
        reset_pulse();
        settle_check(2'h0);
        rd_check(8'h28, 8'h4f);
        rd_check(8'h29, 8'h0c);
        rd_check(8'h2a, 8'h1c);
        $display("test reset_values done");
        reg_lo = 1'b1;
        settle_check(2'h1);
        foreach (SET1_OPS[i]) begin
            wr(SET1_OPS[i][15:8], SET1_OPS[i][7:0]);
            rd_check(SET1_OPS[i][15:8], SET1_OPS[i][7:0]);
            settle_check(2'h1);
        end
        $display("test set1_fields done");
        wr(8'h2b, 8'hff);
        rd_check(8'h2b, 8'h00);
        host.write_reg(7'h2b, 8'h28, 8'h00, ok);
        check("foreign address ack", 64'h0, 64'(ok));
        rd_check(8'h28, shadow[0]);
        $display("test refusals done");
        reg_lo = 1'b0;
        reg_hi = 1'b1;
        settle_check(2'h2);
        foreach (SET2_DATA[i]) begin
            wr(8'h2a, SET2_DATA[i]);
            rd_check(8'h2a, SET2_DATA[i]);
            settle_check(2'h2);
        end
        $display("test set2_fields done");
        pin_lo = 1'b1;
        settle_check(2'h2);
        pin_lo = 1'b0;
        pin_hi = 1'b1;
        wr(8'h2a, 8'h40);
        reg_hi = 1'b0;
        reg_lo = 1'b1;
        settle_check(2'h2);
        pin_hi = 1'b0;
        pin_lo = 1'b1;
        settle_check(2'h1);
        src_other = 1'b1;
        pin_lo = 1'b0;
        pin_hi = 1'b1;
        settle_check(2'h2);
        src_other = 1'b0;
        $display("test mode_source done");
        reset_pulse();
        rd_check(8'h2a, 8'h1c);
        rd_check(8'h29, 8'h0c);
        settle_check(2'h1);
        $display("test second_reset done");
        tally_and_finish();
    end
endmodule // mscr_top_test
`default_nettype wire

// *** rtl/mscr_pkg.sv ***
// types shared by the mode configuration bank
`default_nettype none
package mscr_pkg;
    typedef struct packed {
        logic        core_buck_en;
        logic        system_buck_en;
        logic        aon_en;
        logic        sysreg_en;
        logic [11:0] aon_mv;
        logic [11:0] sysreg_mv;
        logic [11:0] core_buck_mv;
        logic [6:0]  watchdog_s;
        logic        ship;
    } mscr_ctrl_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK
    } mscr_state_t;
endpackage
`default_nettype wire

// *** rtl/mscr_regs.svh ***
// register offsets, reset values, field positions and decode constants for the mode configuration bank
`ifndef MSCR_REGS_SVH
`define MSCR_REGS_SVH

`define MSCR_ADDR_SET1_P2     8'h28
`define MSCR_ADDR_SET1_P3     8'h29
`define MSCR_ADDR_SET2_P0     8'h2a
`define MSCR_RST_SET1_P2      8'h4f
`define MSCR_RST_SET1_P3      8'h0c
`define MSCR_RST_SET2_P0      8'h1c
`define MSCR_RDATA_UNMAPPED   8'h00

`define MSCR_AON_CODE         7:4
`define MSCR_CORE_BUCK_EN     3
`define MSCR_SYSTEM_BUCK_EN   2
`define MSCR_AON_EN           1
`define MSCR_SYSREG_EN        0
`define MSCR_WATCHDOG         7:6
`define MSCR_SYSREG_OFFSET    5
`define MSCR_SYSREG_CODE      4:0
`define MSCR_SHIP             7
`define MSCR_PIN_SELECT       6
`define MSCR_CORE_CODE        5:0

`define MSCR_STEP_MV          12'h0019
`define MSCR_AON_BASE_MV      12'h06a4
`define MSCR_AON_MAX_CODE     4'h8
`define MSCR_SYSREG_BASE_MV   12'h05dc
`define MSCR_SYSREG_MAX_CODE  5'h18
`define MSCR_SYSREG_OFFS_MV   12'h04b0
`define MSCR_CORE_BASE_MV     12'h01f4
`define MSCR_CORE_MAX_CODE    6'h28
`define MSCR_CORE_FIXED_CODE  6'h3f
`define MSCR_CORE_FIXED_MV    12'h0708
`define MSCR_WD_OFF           2'h0
`define MSCR_WD_16            2'h1
`define MSCR_WD_32            2'h2
`define MSCR_WD_64            2'h3
`define MSCR_WD_OFF_S         7'h00
`define MSCR_WD_16_S          7'h10
`define MSCR_WD_32_S          7'h20
`define MSCR_WD_64_S          7'h40

`define MSCR_MODE_SET1        2'h1
`define MSCR_MODE_SET2        2'h2
`define MSCR_BYTE_BITS        4'h8
`define MSCR_FIRST_BIT        4'h1
`define MSCR_ZERO_BITS        4'h0

`endif

// *** rtl/mscr_top.sv ***
// mode configuration register bank with serial slave port and active mode routing
// Functional notes
// R01: set 1 system buck enable bit: 1 on, 0 off; resets 1.
// R02: set 1 always-on regulator enable bit turns it on at 1; resets 1.
// R03: set 1 system regulator enable bit turns it on at 1; resets 1.
// R04: always-on code gives 1.700 V plus 25 mV steps, capped at 1.900 V.
// R05: watchdog field: 00 off, 01 16 s, 10 32 s, 11 64 s; resets 00.
// R06: system regulator offset bit adds 1.2 V when set; resets 0.
// R07: system regulator code 1.500 V plus 25 mV steps, capped 2.100 V; resets 01100.
// R08: in set 2 the ship bit puts the device in ship mode; resets 0.
// R09: set 2 with source select 0 takes the mode from register bits only.
// R10: set 2 with source select 1 takes the mode from the select pins only.
// R11: core buck code 0.500 V plus 25 mV steps up to 1.500 V; resets 011100.
// R12: core buck code all ones gives a fixed 1.8 V.
// R13: every field is writable and reads back last write or reset value.
// R14: set 1 core buck enable bit turns the buck on at 1; resets 1.
// R15: the active mode's fields drive the controls, switching when the mode changes.
`include "mscr_regs.svh"
`default_nettype none
module mscr_top #(
    parameter logic [6:0] DEVICE_ADDR = 7'h2a  // arbitrary value
) (
    // clock and reset
    input  wire logic               i_clock,
    input  wire logic               i_rst,
    // serial slave pins
    input  wire logic               i_scl,
    input  wire logic               i_sda,
    output logic                    o_sda_out,
    output logic                    o_sda_oe,
    // mode sources
    input  wire logic               i_register_mode_bit_low,
    input  wire logic               i_register_mode_bit_high,
    input  wire logic               i_mode_select_pin_low,
    input  wire logic               i_mode_select_pin_high,
    input  wire logic               i_mode_source_pin_select_other,
    // controls of modes held outside this bank
    input  wire mscr_pkg::mscr_ctrl_t i_other_ctrl,
    // routed controls
    output logic [1:0]              o_active_mode,
    output mscr_pkg::mscr_ctrl_t    o_ctrl
);
    logic                  scl_d;
    logic                  sda_d;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  bus_start;
    logic                  bus_stop;
    mscr_pkg::mscr_state_t st;
    mscr_pkg::mscr_state_t after_ack;
    logic [3:0]            nbits;
    logic [7:0]            shreg;
    logic [7:0]            ptr;
    logic                  wr_en;
    logic [7:0]            rdata;
    logic [7:0]            set1_p2;
    logic [7:0]            set1_p3;
    logic [7:0]            set2_p0;
    logic                  pin_source;
    logic [1:0]            next_mode;
    mscr_pkg::mscr_ctrl_t  next_ctrl;

    // bus edge detection
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= i_scl;
            sda_d <= i_sda;
        end
    end

    assign scl_rise  = i_scl & ~scl_d;
    assign scl_fall  = ~i_scl & scl_d;
    assign bus_start = i_scl & scl_d & sda_d & ~i_sda;
    assign bus_stop  = i_scl & scl_d & ~sda_d & i_sda;
    assign wr_en     = (st == mscr_pkg::ST_WDATA) && scl_fall && (nbits == `MSCR_BYTE_BITS) && !bus_stop;
    assign o_sda_out = 1'b0;

    function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] r0,
                                            input logic [7:0] r1, input logic [7:0] r2);
        if (a == `MSCR_ADDR_SET1_P2) begin
            return r0;
        end else if (a == `MSCR_ADDR_SET1_P3) begin
            return r1;
        end else if (a == `MSCR_ADDR_SET2_P0) begin
            return r2;
        end
        return `MSCR_RDATA_UNMAPPED;
    endfunction

    assign rdata = read_reg(ptr, set1_p2, set1_p3, set2_p0);

    // serial slave sequencing
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st        <= mscr_pkg::ST_IDLE;
            after_ack <= mscr_pkg::ST_IDLE;
            nbits     <= `MSCR_ZERO_BITS;
            shreg     <= 8'h00;
            ptr       <= 8'h00;
            o_sda_oe  <= 1'b0;
        end else if (bus_start) begin
            st       <= mscr_pkg::ST_ADDR;
            nbits    <= `MSCR_ZERO_BITS;
            o_sda_oe <= 1'b0;
        end else if (bus_stop) begin
            st       <= mscr_pkg::ST_IDLE;
            o_sda_oe <= 1'b0;
        end else begin
            unique case (st)
                mscr_pkg::ST_IDLE: begin
                    o_sda_oe <= 1'b0;
                end
                mscr_pkg::ST_ADDR, mscr_pkg::ST_PTR, mscr_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], i_sda};
                        nbits <= nbits + `MSCR_FIRST_BIT;
                    end else if (scl_fall && nbits == `MSCR_BYTE_BITS) begin
                        nbits <= `MSCR_ZERO_BITS;
                        if (st == mscr_pkg::ST_ADDR) begin
                            if (shreg[7:1] == DEVICE_ADDR) begin
                                o_sda_oe  <= 1'b1;
                                st        <= mscr_pkg::ST_ACK;
                                after_ack <= shreg[0] ? mscr_pkg::ST_RDATA : mscr_pkg::ST_PTR;
                            end else begin
                                st <= mscr_pkg::ST_IDLE;
                            end
                        end else begin
                            if (st == mscr_pkg::ST_PTR) begin
                                ptr <= shreg;
                            end else begin
                                ptr <= ptr + 8'h01;
                            end
                            o_sda_oe  <= 1'b1;
                            st        <= mscr_pkg::ST_ACK;
                            after_ack <= mscr_pkg::ST_WDATA;
                        end
                    end
                end
                mscr_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        st <= after_ack;
                        if (after_ack == mscr_pkg::ST_RDATA) begin
                            shreg    <= rdata;
                            o_sda_oe <= ~rdata[7];
                            nbits    <= `MSCR_FIRST_BIT;
                            ptr      <= ptr + 8'h01;
                        end else begin
                            o_sda_oe <= 1'b0;
                        end
                    end
                end
                mscr_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        if (nbits == `MSCR_BYTE_BITS) begin
                            o_sda_oe <= 1'b0;
                            st       <= mscr_pkg::ST_RACK;
                        end else begin
                            o_sda_oe <= ~shreg[6];
                            shreg    <= {shreg[6:0], 1'b0};
                            nbits    <= nbits + `MSCR_FIRST_BIT;
                        end
                    end
                end
                mscr_pkg::ST_RACK: begin
                    if (scl_rise && i_sda) begin
                        st <= mscr_pkg::ST_IDLE;
                    end else if (scl_fall) begin
                        shreg    <= rdata;
                        o_sda_oe <= ~rdata[7];
                        nbits    <= `MSCR_FIRST_BIT;
                        ptr      <= ptr + 8'h01;
                        st       <= mscr_pkg::ST_RDATA;
                    end
                end
            endcase
        end
    end

    // configuration storage, read back unchanged
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            set1_p2 <= `MSCR_RST_SET1_P2;  // [R01] [R02] [R03] [R14]
            set1_p3 <= `MSCR_RST_SET1_P3;  // [R05] [R06] [R07]
            set2_p0 <= `MSCR_RST_SET2_P0;  // [R08] [R09] [R11]
        end else if (wr_en) begin
            if (ptr == `MSCR_ADDR_SET1_P2) set1_p2 <= shreg;  // [R13]
            if (ptr == `MSCR_ADDR_SET1_P3) set1_p3 <= shreg;  // [R13]
            if (ptr == `MSCR_ADDR_SET2_P0) set2_p0 <= shreg;  // [R13]
        end
    end

    // active mode source selection
    assign pin_source = (o_active_mode == `MSCR_MODE_SET2) ? set2_p0[`MSCR_PIN_SELECT]
                                                          : i_mode_source_pin_select_other;
    assign next_mode  = pin_source ? {i_mode_select_pin_high, i_mode_select_pin_low}             // [R10]
                                   : {i_register_mode_bit_high, i_register_mode_bit_low};        // [R09]

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_active_mode <= 2'h0;
        end else begin
            o_active_mode <= next_mode;
        end
    end

    // field decode and routing
    always_comb begin
        next_ctrl = i_other_ctrl;
        if (o_active_mode == `MSCR_MODE_SET1) begin  // [R15]
            next_ctrl.core_buck_en   = set1_p2[`MSCR_CORE_BUCK_EN];    // [R14]
            next_ctrl.system_buck_en = set1_p2[`MSCR_SYSTEM_BUCK_EN];  // [R01]
            next_ctrl.aon_en         = set1_p2[`MSCR_AON_EN];          // [R02]
            next_ctrl.sysreg_en      = set1_p2[`MSCR_SYSREG_EN];       // [R03]
            next_ctrl.aon_mv = (set1_p2[`MSCR_AON_CODE] > `MSCR_AON_MAX_CODE)
                ? 12'(`MSCR_AON_BASE_MV + `MSCR_STEP_MV * `MSCR_AON_MAX_CODE)
                : 12'(`MSCR_AON_BASE_MV + `MSCR_STEP_MV * set1_p2[`MSCR_AON_CODE]);  // [R04]
            next_ctrl.sysreg_mv = 12'(((set1_p3[`MSCR_SYSREG_CODE] > `MSCR_SYSREG_MAX_CODE)
                ? 12'(`MSCR_SYSREG_BASE_MV + `MSCR_STEP_MV * `MSCR_SYSREG_MAX_CODE)
                : 12'(`MSCR_SYSREG_BASE_MV + `MSCR_STEP_MV * set1_p3[`MSCR_SYSREG_CODE]))
                + (set1_p3[`MSCR_SYSREG_OFFSET] ? `MSCR_SYSREG_OFFS_MV : 12'h0000));  // [R06] [R07]
            unique case (set1_p3[`MSCR_WATCHDOG])  // [R05]
                `MSCR_WD_OFF: next_ctrl.watchdog_s = `MSCR_WD_OFF_S;
                `MSCR_WD_16:  next_ctrl.watchdog_s = `MSCR_WD_16_S;
                `MSCR_WD_32:  next_ctrl.watchdog_s = `MSCR_WD_32_S;
                `MSCR_WD_64:  next_ctrl.watchdog_s = `MSCR_WD_64_S;
            endcase
        end else if (o_active_mode == `MSCR_MODE_SET2) begin  // [R15]
            next_ctrl.ship = set2_p0[`MSCR_SHIP];  // [R08]
            if (set2_p0[`MSCR_CORE_CODE] == `MSCR_CORE_FIXED_CODE) begin
                next_ctrl.core_buck_mv = `MSCR_CORE_FIXED_MV;  // [R12]
            end else if (set2_p0[`MSCR_CORE_CODE] > `MSCR_CORE_MAX_CODE) begin
                next_ctrl.core_buck_mv = 12'(`MSCR_CORE_BASE_MV + `MSCR_STEP_MV * `MSCR_CORE_MAX_CODE);  // [R11]
            end else begin
                next_ctrl.core_buck_mv = 12'(`MSCR_CORE_BASE_MV + `MSCR_STEP_MV * set2_p0[`MSCR_CORE_CODE]);  // [R11]
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_ctrl <= '0;
        end else begin
            o_ctrl <= next_ctrl;
        end
    end

    // checks
    sequence write_taken_s;
        wr_en ##1 (st == mscr_pkg::ST_ACK);
    endsequence

    property set1_en_p(logic en_out, logic en_bit);
        @(posedge i_clock) disable iff (i_rst)
        (o_active_mode == `MSCR_MODE_SET1) |=> (en_out == $past(en_bit));
    endproperty

    sysbuck_en_a: assert property (set1_en_p(o_ctrl.system_buck_en, set1_p2[`MSCR_SYSTEM_BUCK_EN]))  // [R01]
        else $error("system buck enable not routed");
    aon_en_a: assert property (set1_en_p(o_ctrl.aon_en, set1_p2[`MSCR_AON_EN]))  // [R02]
        else $error("aon regulator enable not routed");
    sysreg_en_a: assert property (set1_en_p(o_ctrl.sysreg_en, set1_p2[`MSCR_SYSREG_EN]))  // [R03]
        else $error("system regulator enable not routed");
    corebuck_en_a: assert property (set1_en_p(o_ctrl.core_buck_en, set1_p2[`MSCR_CORE_BUCK_EN]))  // [R14]
        else $error("core buck enable not routed");
    aon_cap_a: assert property (@(posedge i_clock) disable iff (i_rst)  // [R04]
        (o_active_mode == `MSCR_MODE_SET1 && set1_p2[`MSCR_AON_CODE] >= `MSCR_AON_MAX_CODE)
        |=> o_ctrl.aon_mv == 12'h076c)
        else $error("aon voltage cap wrong");
    watchdog_64_a: assert property (@(posedge i_clock) disable iff (i_rst)  // [R05]
        (o_active_mode == `MSCR_MODE_SET1 && set1_p3[`MSCR_WATCHDOG] == 2'h3) |=> o_ctrl.watchdog_s == 7'h40)
        else $error("watchdog period wrong");
    sysreg_offs_a: assert property (@(posedge i_clock) disable iff (i_rst)  // [R06] [R07]
        (o_active_mode == `MSCR_MODE_SET1 && set1_p3[`MSCR_SYSREG_OFFSET] && set1_p3[`MSCR_SYSREG_CODE] == 5'h00)
        |=> o_ctrl.sysreg_mv == 12'h0a8c)
        else $error("system regulator offset wrong");
    ship_route_a: assert property (@(posedge i_clock) disable iff (i_rst)  // [R08]
        (o_active_mode == `MSCR_MODE_SET2) |=> o_ctrl.ship == $past(set2_p0[`MSCR_SHIP]))
        else $error("ship mode not routed");
    reg_source_a: assert property (@(posedge i_clock) disable iff (i_rst)  // [R09]
        (o_active_mode == `MSCR_MODE_SET2 && !set2_p0[`MSCR_PIN_SELECT])
        |=> o_active_mode == $past({i_register_mode_bit_high, i_register_mode_bit_low}))
        else $error("register mode bits ignored");
    pin_source_a: assert property (@(posedge i_clock) disable iff (i_rst)  // [R10]
        (o_active_mode == `MSCR_MODE_SET2 && set2_p0[`MSCR_PIN_SELECT])
        |=> o_active_mode == $past({i_mode_select_pin_high, i_mode_select_pin_low}))
        else $error("mode pins ignored");
    core_fixed_a: assert property (@(posedge i_clock) disable iff (i_rst)  // [R12]
        (o_active_mode == `MSCR_MODE_SET2 && set2_p0[`MSCR_CORE_CODE] == 6'h3f) |=> o_ctrl.core_buck_mv == 12'h0708)
        else $error("core buck fixed voltage wrong");
    core_cap_a: assert property (@(posedge i_clock) disable iff (i_rst)  // [R11]
        (o_active_mode == `MSCR_MODE_SET2 && set2_p0[`MSCR_CORE_CODE] == 6'h28) |=> o_ctrl.core_buck_mv == 12'h05dc)
        else $error("core buck top voltage wrong");
    write_back_a: assert property (@(posedge i_clock) disable iff (i_rst)  // [R13]
        (wr_en && ptr == `MSCR_ADDR_SET1_P3) ##0 write_taken_s |-> set1_p3 == $past(shreg))
        else $error("written value not stored");
endmodule // mscr_top
`default_nettype wire
